// ===== rtl/dslc_pkg.sv
`default_nettype none
// ==========================================================
// shared constants of the drive status lamp controller
// ==========================================================
package dslc_pkg;
  // clock and the millisecond tick derived from it
  localparam int DSLC_CLK_PERIOD_PS = 4000;      // 250 mhz system clock
  localparam int DSLC_MS_PS         = 1000000000; // one millisecond
  localparam int DSLC_MS_CYCLES     = DSLC_MS_PS / DSLC_CLK_PERIOD_PS;

  // lamp pattern durations, in milliseconds
  localparam int DSLC_BLINK_MS    = 200;  // blink on and off half
  localparam int DSLC_SF_ON_MS    = 200;  // single flash lit part
  localparam int DSLC_SF_OFF_MS   = 1000; // single flash dark part
  localparam int DSLC_DF_ON_MS    = 200;  // each flash of a double
  localparam int DSLC_DF_OFF_MS   = 1000; // pause after a double
  localparam int DSLC_FLICK_MS    = 50;   // flicker half period
  localparam int DSLC_SIM_MS      = 500;  // one simulation phase
  localparam int DSLC_ACT_HOLD_MS = 50;   // activity stretch per frame
  localparam int DSLC_ALARM_GAP   = 3;    // dark blink slots per group

  // pattern counter width and reset values
  localparam int              DSLC_CW        = 12;
  localparam logic [11:0]     DSLC_CNT_RST   = 12'h000;
  localparam logic [15:0]     DSLC_ILK_RST   = 16'h0000;
  localparam logic [1:0]      DSLC_PHASE_RST = 2'h0;

  // bus slave state codes
  localparam logic [1:0] DSLC_BUS_INIT   = 2'h0;
  localparam logic [1:0] DSLC_BUS_PREOP  = 2'h1;
  localparam logic [1:0] DSLC_BUS_SAFEOP = 2'h2;
  localparam logic [1:0] DSLC_BUS_OP     = 2'h3;

  // bus error class codes
  localparam logic [1:0] DSLC_ERR_NONE = 2'h0;
  localparam logic [1:0] DSLC_ERR_CFG  = 2'h1;
  localparam logic [1:0] DSLC_ERR_DATA = 2'h2;
  localparam logic [1:0] DSLC_ERR_WDOG = 2'h3;

  // simulation phases
  localparam logic [1:0] DSLC_SIM_GREEN = 2'h0;
  localparam logic [1:0] DSLC_SIM_RED   = 2'h1;
  localparam logic [1:0] DSLC_SIM_BOTH  = 2'h2;

  // power/alarm lamp display modes, in priority order, highest first after off
  typedef enum logic [2:0] {
    DSLC_M_OFF, DSLC_M_ALARM, DSLC_M_REMOVAL, DSLC_M_ORIGIN,
    DSLC_M_INTERLOCK, DSLC_M_INFO, DSLC_M_SIM, DSLC_M_STEADY
  } dslc_mode_t;
endpackage
`default_nettype wire

// ===== rtl/dslc_pat_if.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// pattern waveforms from generator to lamp logic
// ==========================================================
interface dslc_pat_if;
  logic       ms_tick;    // one pulse per millisecond
  logic       blink_on;   // blink waveform
  logic       blink_wrap; // pulse at end of each blink period
  logic       single_on;  // single flash waveform
  logic       double_on;  // double flash waveform
  logic       flicker_on; // flicker waveform
  logic [1:0] sim_phase;  // simulation phase index
  modport gen (output ms_tick, blink_on, blink_wrap, single_on,
               double_on, flicker_on, sim_phase);
  modport use_p (input ms_tick, blink_on, blink_wrap, single_on,
                 double_on, flicker_on, sim_phase);
endinterface
`default_nettype wire

// ===== rtl/dslc_pattern_gen.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// millisecond prescaler and pattern waveform counters
// ==========================================================
module dslc_pattern_gen #(
  parameter int MS_CYCLES = dslc_pkg::DSLC_MS_CYCLES,
  parameter int BLINK_MS  = dslc_pkg::DSLC_BLINK_MS,
  parameter int SF_ON_MS  = dslc_pkg::DSLC_SF_ON_MS,
  parameter int SF_OFF_MS = dslc_pkg::DSLC_SF_OFF_MS,
  parameter int DF_ON_MS  = dslc_pkg::DSLC_DF_ON_MS,
  parameter int DF_OFF_MS = dslc_pkg::DSLC_DF_OFF_MS,
  parameter int FLICK_MS  = dslc_pkg::DSLC_FLICK_MS,
  parameter int SIM_MS    = dslc_pkg::DSLC_SIM_MS
) (
  // clock and reset
  input  wire logic   clk_in,
  input  wire logic   rst_b_in,
  // waveforms out
  dslc_pat_if.gen     pat
);
  import dslc_pkg::*;

  localparam int PW = (MS_CYCLES > 1) ? $clog2(MS_CYCLES) : 1;
  localparam int NPAT = 5; // blink, single, double, flicker, sim
  localparam int PERIOD [NPAT] = '{2 * BLINK_MS, SF_ON_MS + SF_OFF_MS,
    3 * DF_ON_MS + DF_OFF_MS, 2 * FLICK_MS, SIM_MS};

  logic [PW-1:0]      pre_q;             // cycles within a millisecond
  logic               tick;              // last cycle of a millisecond
  logic [DSLC_CW-1:0] cnt_q [NPAT];      // ms within each pattern period
  logic [NPAT-1:0]    wrap;              // pattern period ends
  logic [1:0]         phase_q;           // simulation phase

  // ==========================================================
  // millisecond prescaler
  // ==========================================================
  assign tick = (pre_q == PW'(MS_CYCLES - 1)); // see RULE12

  // free running, so every lamp pattern shares one time base
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || tick) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PW'(1);
    end
  end

  // no two ticks back to back when a millisecond spans cycles
  AST_MS_TICK_SPACING: assert property (@(posedge clk_in) // see RULE12
    disable iff (!rst_b_in) (MS_CYCLES > 1) && tick |=> !tick)
    else $error("millisecond tick repeated");

  // ==========================================================
  // one period counter per pattern
  // ==========================================================
  genvar gi;
  generate
    for (gi = 0; gi < NPAT; gi++) begin : g_pat
      assign wrap[gi] = tick &&
        (cnt_q[gi] == DSLC_CW'(PERIOD[gi] - 1));
      // counts milliseconds, restarts at period end
      always_ff @(posedge clk_in) begin
        if (!rst_b_in || wrap[gi]) begin
          cnt_q[gi] <= DSLC_CNT_RST;
        end else if (tick) begin
          cnt_q[gi] <= cnt_q[gi] + DSLC_CW'(1); // see RULE12
        end
      end
    end
  endgenerate

  // simulation phase steps through four phases forever
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      phase_q <= DSLC_PHASE_RST;
    end else if (wrap[4]) begin
      phase_q <= phase_q + 2'h1; // see RULE8
    end
  end

  // ==========================================================
  // waveform decode
  // ==========================================================
  assign pat.ms_tick    = tick;
  assign pat.blink_on   = cnt_q[0] < DSLC_CW'(BLINK_MS);
  assign pat.blink_wrap = wrap[0];
  assign pat.single_on  = cnt_q[1] < DSLC_CW'(SF_ON_MS);
  // lit, dark, lit, then the long pause
  assign pat.double_on  = (cnt_q[2] < DSLC_CW'(DF_ON_MS)) ||
    ((cnt_q[2] >= DSLC_CW'(2 * DF_ON_MS)) &&
     (cnt_q[2] <  DSLC_CW'(3 * DF_ON_MS)));
  assign pat.flicker_on = cnt_q[3] < DSLC_CW'(FLICK_MS);
  assign pat.sim_phase  = phase_q;
endmodule
`default_nettype wire

// ===== rtl/dslc_lamp_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// RULE1 - power only: green steady, red off
// RULE2 - alarm: red blinks code count, green off
// RULE3 - power removal: green blinks, red off
// RULE4 - information: both double blink together
// RULE5 - remote operation: same double blink
// RULE6 - interlock release: both blink until timeout
// RULE7 - origin input function: both steadily lit
// RULE8 - simulation: green, red, both, off, repeat
// RULE9 - run lamp follows bus slave state
// RULE10 - error lamp follows bus error class
// RULE11 - link lamp: off, on, flicker on frames
// RULE12 - pattern timings in ms from prescaler
// RULE13 - one pattern by fixed priority, alarm first
module dslc_lamp_ctrl #(
  parameter int MS_CYCLES = dslc_pkg::DSLC_MS_CYCLES,
  parameter int NPORT     = 2,
  parameter int CODE_W    = 8
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  // drive conditions
  input  wire logic              ctrl_power_in,
  input  wire logic              alarm_active_in,
  input  wire logic [CODE_W-1:0] alarm_code_in,
  input  wire logic              power_removal_in,
  input  wire logic              info_pending_in,
  input  wire logic              remote_op_in,
  input  wire logic              interlock_release_in,
  input  wire logic [15:0]       extended_input_interlock_ms_in,
  input  wire logic              origin_func_busy_in,
  input  wire logic              sim_mode_in,
  // fieldbus conditions
  input  wire logic [1:0]        bus_state_in,
  input  wire logic [1:0]        bus_error_in,
  input  wire logic [NPORT-1:0]  link_up_in,
  input  wire logic [NPORT-1:0]  link_activity_in,
  // lamp drives
  output logic                   power_alarm_lamp_green_out,
  output logic                   power_alarm_lamp_red_out,
  output logic                   bus_run_lamp_out,
  output logic                   bus_error_lamp_out,
  output logic [NPORT-1:0]       link_lamp_out
);
  import dslc_pkg::*;

  localparam int SW = CODE_W + 2; // room for code plus gap slots

  dslc_pat_if                pat ();      // shared waveforms
  dslc_mode_t                mode;        // selected display mode
  logic [15:0]               ilk_q;       // interlock ms remaining
  logic [SW-1:0]             slot_q;      // blink slot within group
  logic [SW-1:0]             code_eff;    // blinks per group, min 1
  logic                      grn_d;       // next green
  logic                      red_d;       // next red
  logic                      run_d;       // next run lamp
  logic                      err_d;       // next error lamp
  logic [DSLC_CW-1:0]        act_q [NPORT]; // activity stretch

  // ==========================================================
  // pattern generator
  // ==========================================================
  dslc_pattern_gen #(
    .MS_CYCLES (MS_CYCLES)
  ) u_gen (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .pat      (pat)
  );

  // ==========================================================
  // interlock release timer
  // ==========================================================
  // a fresh release reloads even mid count, so it is never lost
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      ilk_q <= DSLC_ILK_RST;
    end else if (interlock_release_in) begin
      ilk_q <= extended_input_interlock_ms_in; // see RULE6
    end else if (pat.ms_tick && (ilk_q != 16'h0000)) begin
      ilk_q <= ilk_q - 16'h0001; // see RULE6
    end
  end

  // ==========================================================
  // mode selection by priority
  // ==========================================================
  // alarm over power removal over the rest; no power, power/alarm lamp dark
  always_comb begin
    if (!ctrl_power_in) begin
      mode = DSLC_M_OFF;
    end else if (alarm_active_in) begin
      mode = DSLC_M_ALARM; // see RULE13
    end else if (power_removal_in) begin
      mode = DSLC_M_REMOVAL; // see RULE13
    end else if (origin_func_busy_in) begin
      mode = DSLC_M_ORIGIN;
    end else if (ilk_q != 16'h0000) begin
      mode = DSLC_M_INTERLOCK;
    end else if (info_pending_in || remote_op_in) begin
      mode = DSLC_M_INFO; // see RULE5
    end else if (sim_mode_in) begin
      mode = DSLC_M_SIM;
    end else begin
      mode = DSLC_M_STEADY;
    end
  end

  // ==========================================================
  // alarm blink grouping
  // ==========================================================
  // code zero still shows one blink so an alarm is never dark
  assign code_eff = (alarm_code_in == '0) ? SW'(1) :
                    SW'(alarm_code_in);

  // one slot per blink period; code slots lit, then gap slots
  always_ff @(posedge clk_in) begin
    if (!rst_b_in || (mode != DSLC_M_ALARM)) begin
      slot_q <= '0;
    end else if (pat.blink_wrap) begin
      if (slot_q >= code_eff + SW'(DSLC_ALARM_GAP - 1)) begin
        slot_q <= '0; // see RULE2
      end else begin
        slot_q <= slot_q + SW'(1);
      end
    end
  end

  // ==========================================================
  // power/alarm lamp decode
  // ==========================================================
  always_comb begin
    grn_d = 1'b0;
    red_d = 1'b0;
    case (mode)
      DSLC_M_OFF: begin
        grn_d = 1'b0; // lamp dark without control power
      end
      DSLC_M_ALARM: begin
        red_d = pat.blink_on && (slot_q < code_eff); // see RULE2
      end
      DSLC_M_REMOVAL: begin
        grn_d = pat.blink_on; // see RULE3
      end
      DSLC_M_ORIGIN: begin
        grn_d = 1'b1; // see RULE7
        red_d = 1'b1;
      end
      DSLC_M_INTERLOCK: begin
        grn_d = pat.blink_on; // see RULE6
        red_d = pat.blink_on;
      end
      DSLC_M_INFO: begin
        grn_d = pat.double_on; // see RULE4
        red_d = pat.double_on;
      end
      DSLC_M_SIM: begin
        // final phase leaves both dark
        grn_d = (pat.sim_phase == DSLC_SIM_GREEN) ||
                (pat.sim_phase == DSLC_SIM_BOTH); // see RULE8
        red_d = (pat.sim_phase == DSLC_SIM_RED) ||
                (pat.sim_phase == DSLC_SIM_BOTH);
      end
      DSLC_M_STEADY: begin
        grn_d = 1'b1; // see RULE1
      end
      default: begin
        grn_d = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // fieldbus lamps decode
  // ==========================================================
  always_comb begin
    case (bus_state_in)
      DSLC_BUS_INIT:   run_d = 1'b0; // see RULE9
      DSLC_BUS_PREOP:  run_d = pat.blink_on;
      DSLC_BUS_SAFEOP: run_d = pat.single_on;
      DSLC_BUS_OP:     run_d = 1'b1;
      default:         run_d = 1'b0;
    endcase
    case (bus_error_in)
      DSLC_ERR_NONE: err_d = 1'b0; // see RULE10
      DSLC_ERR_CFG:  err_d = pat.blink_on;
      DSLC_ERR_DATA: err_d = pat.single_on;
      DSLC_ERR_WDOG: err_d = pat.double_on;
      default:       err_d = 1'b0;
    endcase
  end

  // registered lamp drives, so no decode glitch reaches a pin
  always_ff @(posedge clk_in) begin
    if (!rst_b_in) begin
      power_alarm_lamp_green_out <= 1'b0;
      power_alarm_lamp_red_out   <= 1'b0;
      bus_run_lamp_out           <= 1'b0;
      bus_error_lamp_out         <= 1'b0;
    end else begin
      power_alarm_lamp_green_out <= grn_d;
      power_alarm_lamp_red_out   <= red_d;
      bus_run_lamp_out           <= run_d;
      bus_error_lamp_out         <= err_d;
    end
  end

  // ==========================================================
  // link/activity lamps, one per port
  // ==========================================================
  genvar gp;
  generate
    for (gp = 0; gp < NPORT; gp++) begin : g_port
      // single frames are too short to see, so stretch them
      always_ff @(posedge clk_in) begin
        if (!rst_b_in || !link_up_in[gp]) begin
          act_q[gp] <= DSLC_CNT_RST;
        end else if (link_activity_in[gp]) begin
          act_q[gp] <= DSLC_CW'(DSLC_ACT_HOLD_MS); // see RULE11
        end else if (pat.ms_tick && (act_q[gp] != '0)) begin
          act_q[gp] <= act_q[gp] - DSLC_CW'(1);
        end
      end
      // off without link, flicker with traffic, else lit
      always_ff @(posedge clk_in) begin
        if (!rst_b_in || !link_up_in[gp]) begin
          link_lamp_out[gp] <= 1'b0; // see RULE11
        end else if (act_q[gp] != '0) begin
          link_lamp_out[gp] <= pat.flicker_on;
        end else begin
          link_lamp_out[gp] <= 1'b1;
        end
      end
    end
  endgenerate

  // ==========================================================
  // checks
  // ==========================================================
  AST_STEADY_GREEN: assert property (@(posedge clk_in) // see RULE1
    disable iff (!rst_b_in) mode == DSLC_M_STEADY
    |=> power_alarm_lamp_green_out && !power_alarm_lamp_red_out)
    else $error("steady green not shown");
  AST_ALARM_FIRST: assert property (@(posedge clk_in) // see RULE13
    disable iff (!rst_b_in) ctrl_power_in && alarm_active_in
    |=> !power_alarm_lamp_green_out)
    else $error("green lit during alarm");
  AST_ALARM_GROUP: assert property (@(posedge clk_in) // see RULE2
    disable iff (!rst_b_in) mode == DSLC_M_ALARM && slot_q >= code_eff
    |=> !power_alarm_lamp_red_out)
    else $error("red lit in alarm gap");
  AST_REMOVAL_BLINK: assert property (@(posedge clk_in) // see RULE3
    disable iff (!rst_b_in) mode == DSLC_M_REMOVAL
    |=> !power_alarm_lamp_red_out &&
        power_alarm_lamp_green_out == $past(pat.blink_on))
    else $error("power removal pattern wrong");
  AST_INFO_DOUBLE: assert property (@(posedge clk_in) // see RULE5
    disable iff (!rst_b_in) ctrl_power_in && !alarm_active_in &&
      !power_removal_in && !origin_func_busy_in && ilk_q == 16'h0000 &&
      remote_op_in |=> power_alarm_lamp_red_out ==
      power_alarm_lamp_green_out &&
      power_alarm_lamp_red_out == $past(pat.double_on))
    else $error("double blink pattern wrong");
  AST_INTERLOCK_LOAD: assert property (@(posedge clk_in) // see RULE6
    disable iff (!rst_b_in) interlock_release_in &&
      extended_input_interlock_ms_in > 16'h0001
    |=> ##1 ilk_q != 16'h0000)
    else $error("interlock timer not started");
  AST_ORIGIN_BOTH: assert property (@(posedge clk_in) // see RULE7
    disable iff (!rst_b_in) mode == DSLC_M_ORIGIN
    |=> power_alarm_lamp_green_out && power_alarm_lamp_red_out)
    else $error("origin function not shown");
  AST_SIM_DARK: assert property (@(posedge clk_in) // see RULE8
    disable iff (!rst_b_in) mode == DSLC_M_SIM && pat.sim_phase == 2'h3
    |=> !power_alarm_lamp_green_out && !power_alarm_lamp_red_out)
    else $error("simulation dark phase lit");
  AST_RUN_STATE: assert property (@(posedge clk_in) // see RULE9
    disable iff (!rst_b_in) bus_state_in == DSLC_BUS_SAFEOP
    |=> bus_run_lamp_out == $past(pat.single_on))
    else $error("run lamp not single flash");
  AST_ERR_WDOG: assert property (@(posedge clk_in) // see RULE10
    disable iff (!rst_b_in) bus_error_in == DSLC_ERR_WDOG
    |=> bus_error_lamp_out == $past(pat.double_on))
    else $error("error lamp not double flash");
  AST_LINK_OFF: assert property (@(posedge clk_in) // see RULE11
    disable iff (!rst_b_in) !link_up_in[0] |=> !link_lamp_out[0])
    else $error("link lamp lit without link");
endmodule
`default_nettype wire

// ===== tb/dslc_lamp_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// lamp side observer: counts lit cycles and turn-on events
// ==========================================================
module dslc_lamp_model (
  // clock and window control
  input  wire logic clk_in,
  input  wire logic clr_in,     // restarts every count
  // lamp drives seen by the eye
  input  wire logic pa_g_in,    // power/alarm green element
  input  wire logic pa_r_in,    // power/alarm red element
  input  wire logic run_in,     // bus run lamp
  input  wire logic err_in,     // bus error lamp
  // counts over the window
  output int        g_on_out,   // green lit cycles
  output int        r_on_out,   // red lit cycles
  output int        g_rise_out, // green turn-on events
  output int        r_rise_out, // red turn-on events
  output int        neq_out,    // cycles where colours differ
  output int        run_on_out, // run lamp lit cycles
  output int        err_on_out  // error lamp lit cycles
);
  logic g_prev; // last green level, for turn-on events
  logic r_prev; // last red level
  // a lamp is passive, so the model only watches; an unknown drive
  // never counts as lit because the compare below is four-state
  always @(posedge clk_in) begin
    if (clr_in) begin
      {g_on_out, r_on_out, g_rise_out, r_rise_out} = '0;
      {neq_out, run_on_out, err_on_out} = '0;
    end else begin
      g_on_out   += (pa_g_in === 1'b1);
      r_on_out   += (pa_r_in === 1'b1);
      g_rise_out += (pa_g_in === 1'b1 && g_prev === 1'b0);
      r_rise_out += (pa_r_in === 1'b1 && r_prev === 1'b0);
      neq_out    += (pa_g_in !== pa_r_in);
      run_on_out += (run_in === 1'b1);
      err_on_out += (err_in === 1'b1);
    end
    g_prev = pa_g_in;
    r_prev = pa_r_in;
  end
endmodule
`default_nettype wire

// ===== tb/drive_status_lamp_controller_bench.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// self-checking bench, prescaler shrunk to 4 cycles per ms
// ==========================================================
module drive_status_lamp_controller_bench;
  import dslc_pkg::*;
  localparam int MSC = 4; // cycles per ms; 200 ms blink = 800 cycles
  // stimulus
  logic       clk_in = 1'b0, rst_b_in = 1'b0, pwr = 1'b0, alm = 1'b0;
  logic [7:0] code = 8'h00;
  logic       rmv = 1'b0, info = 1'b0, remote = 1'b0, ilk = 1'b0;
  logic [15:0] ilk_ms = 16'h0000;
  logic       org = 1'b0, sim = 1'b0, clr = 1'b1;
  logic [1:0] bst = 2'h0, berr = 2'h0, lup = 2'h0, lact = 2'h0;
  // observed
  logic       g, r, run, err;
  logic [1:0] llamp;
  int         g_on, r_on, g_rise, r_rise, neq, run_on, err_on;
  int         n_errors = 0, num_checks = 0;
  int         win[4] = '{1600, 1600, 4800, 6400};
  int         run_x[4] = '{0, 800, 800, 6400};
  int         err_x[4] = '{0, 800, 800, 1600};
  int         low;

  always #2 clk_in = ~clk_in;

  dslc_lamp_ctrl #(.MS_CYCLES(MSC), .NPORT(2), .CODE_W(8)) u_dut (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .ctrl_power_in(pwr),
    .alarm_active_in(alm), .alarm_code_in(code),
    .power_removal_in(rmv), .info_pending_in(info),
    .remote_op_in(remote), .interlock_release_in(ilk),
    .extended_input_interlock_ms_in(ilk_ms),
    .origin_func_busy_in(org), .sim_mode_in(sim),
    .bus_state_in(bst), .bus_error_in(berr), .link_up_in(lup),
    .link_activity_in(lact), .power_alarm_lamp_green_out(g),
    .power_alarm_lamp_red_out(r), .bus_run_lamp_out(run),
    .bus_error_lamp_out(err), .link_lamp_out(llamp));

  dslc_lamp_model u_lamps (
    .clk_in(clk_in), .clr_in(clr), .pa_g_in(g), .pa_r_in(r),
    .run_in(run), .err_in(err), .g_on_out(g_on), .r_on_out(r_on),
    .g_rise_out(g_rise), .r_rise_out(r_rise), .neq_out(neq),
    .run_on_out(run_on), .err_on_out(err_on));

  // ==========================================================
  // shared helpers
  // ==========================================================
  // wide enough for four packed counts, so no part of a group is lost
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // count over n edges; windows span whole pattern periods, so the
  // free-running phase does not change the totals
  task automatic measure(input int n);
    @(negedge clk_in) clr = 1'b1;
    repeat (2) @(negedge clk_in);
    clr = 1'b0;
    repeat (n) @(posedge clk_in);
    @(negedge clk_in);
  endtask

  task automatic finish_test();
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ==========================================================
  // scenarios
  // ==========================================================
  task automatic t_power();
    measure(100);
    check(g_on + r_on, 0);
    @(negedge clk_in) pwr = 1'b1;
    measure(500);
    check(g_on, 500);
    check(r_on, 0);
    $display("test power done");
  endtask

  task automatic t_alarm();
    @(negedge clk_in) {alm, code, rmv, info} = {1'b1, 8'h02, 2'b11};
    repeat (8000) @(negedge clk_in);
    measure(8000); // one group: code plus three dark slots
    check(r_rise, 2);
    check(g_on, 0);
    @(negedge clk_in) alm = 1'b0;
    measure(1600); // removal now wins over info
    check({g_rise, r_on, g_on}, {32'd1, 32'd0, 32'd800});
    @(negedge clk_in) rmv = 1'b0;
    measure(6400);
    check({g_rise, neq, g_on}, {32'd2, 32'd0, 32'd1600});
    {info, remote} = 2'b01;
    measure(6400);
    check({g_rise, neq, g_on}, {32'd2, 32'd0, 32'd1600});
    @(negedge clk_in) remote = 1'b0;
    measure(200);
    check({g_on, r_on}, {32'd200, 32'd0});
    $display("test alarm and blink modes done");
  endtask

  task automatic t_interlock();
    @(negedge clk_in) {ilk, ilk_ms} = {1'b1, 16'd500};
    @(negedge clk_in) ilk = 1'b0;
    measure(1800); // 500 ms is 2000 cycles
    check(neq, 0);
    check(g_on > 0 && g_on < 1800, 1'b1);
    repeat (400) @(negedge clk_in);
    measure(100);
    check({g_on, r_on}, {32'd100, 32'd0});
    org = 1'b1;
    measure(300);
    check({g_on, r_on}, {32'd300, 32'd300});
    @(negedge clk_in) org = 1'b0;
    measure(50);
    check(r_on, 0);
    $display("test interlock and origin done");
  endtask

  task automatic t_sim();
    @(negedge clk_in) sim = 1'b1;
    measure(8000); // four phases of 500 ms
    check({g_on, r_on, neq, g_rise}, {32'd4000, 32'd4000, 32'd4000,
          32'd2});
    @(negedge clk_in) sim = 1'b0;
    $display("test simulation mode done");
  endtask

  task automatic t_bus();
    for (int i = 0; i < 4; i++) begin
      @(negedge clk_in) {bst, berr} = {i[1:0], i[1:0]};
      measure(win[i]);
      check(run_on, run_x[i]);
      check(err_on, err_x[i]);
    end
    $display("test bus lamps done");
  endtask

  task automatic t_link();
    check(llamp, 2'b00);
    @(negedge clk_in) lup = 2'b11;
    repeat (2) @(negedge clk_in);
    check(llamp, 2'b11);
    low = 0;
    // a frame every 8 cycles keeps the stretch alive all window long;
    // one lone frame may fall wholly inside a lit flicker half
    for (int k = 0; k < 240; k++) begin
      lact = {k[2:0] == 3'h0, 1'b0};
      @(negedge clk_in);
      low += (llamp[1] === 1'b0);
      check(llamp[0], 1'b1);
    end
    lact = 2'b00;
    check(low > 0, 1'b1);
    repeat (260) @(negedge clk_in);
    check(llamp, 2'b11);
    lup = 2'b01;
    repeat (2) @(negedge clk_in);
    check(llamp, 2'b01);
    $display("test link lamps done");
  endtask

  // ==========================================================
  // main sequence and watchdog
  // ==========================================================
  initial begin
    repeat (20) @(negedge clk_in);
    check({g, r, run, err, llamp}, 6'h00);
    rst_b_in = 1'b1;
    t_power();
    t_alarm();
    t_interlock();
    t_sim();
    t_bus();
    t_link();
    finish_test();
  end

  // about 57000 cycles expected; give up at 90000 cycles
  initial begin
    #360000;
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
